// ---- gtm_map.vh ----
`ifndef GTM_MAP_VH
`define GTM_MAP_VH
// Register byte addresses on the AXI4-Lite bus.
`define GTM_ADDR_CTRL 8'h00
`define GTM_ADDR_GATE 8'h04
`define GTM_ADDR_CNTL 8'h08
`define GTM_ADDR_CNTH 8'h0C
`define GTM_AW 4
// Counter control field positions.
`define GTM_CS_HI 7
`define GTM_CS_LO 6
`define GTM_PS_HI 5
`define GTM_PS_LO 4
`define GTM_OSCEN 3
`define GTM_SYNCB 2
`define GTM_ON 0
`define GTM_CTRL_WMASK 8'hFD
// Gate control field positions.
`define GTM_GE 7
`define GTM_GPOL 6
`define GTM_GTM 5
`define GTM_GSPM 4
`define GTM_GARM 3
`define GTM_GVAL 2
`define GTM_GSS_HI 1
`define GTM_GSS_LO 0
`define GTM_GATE_WMASK 8'hFB
// Flag register: bit 7 gate event, bit 0 overflow; writing 1 clears.
`define GTM_ADDR_FLAG 8'h10
`define GTM_ADDR_IEN 8'h14
`define GTM_FLAG_GATE 7
`define GTM_FLAG_OVF 0
// Irq control: bit 7 global, bit 6 peripheral.
`define GTM_ADDR_IRQC 8'h18
`define GTM_IRQ_GIE 7
`define GTM_IRQ_PERIPHERAL_IRQ_ENABLE 6
// Capture/compare pair.
`define GTM_ADDR_CCL 8'h1C
`define GTM_ADDR_CCH 8'h20
// Clock source codes.
`define GTM_CS_INSTR 2'h0
`define GTM_CS_SYS 2'h1
`define GTM_CS_EXT 2'h2
`define GTM_CS_LFO 2'h3
// Gate source codes, then the instruction divider terminal count and the bus response codes.
`define GTM_GS_PIN 2'h0
`define GTM_GS_TICK 2'h1
`define GTM_GS_PER 2'h2
`define GTM_INSTR_DIV 2'h3
`define GTM_RESP_OK 2'h0
`define GTM_RESP_SLVERR 2'h2
`endif

// ---- gtm_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// Stands in for the gate pin, the count pin and the two neighbour timers.
module gtm_partner (
   input wire logic clock,
   output logic gate_input_pin,
   output logic tick_timer_wrap,
   output logic period_timer_match,
   output logic external_count_pin
);
   initial begin
      gate_input_pin = 1'b1;
      tick_timer_wrap = 1'b0;
      period_timer_match = 1'b0;
      external_count_pin = 1'b0;
   end
   // The gap sets the half period, so slow and prompt edges both come from here.
   task automatic pins(input int n, input int gap);
      repeat (n) begin
         repeat (gap) @(posedge clock);
         external_count_pin <= 1'b1;
         repeat (gap) @(posedge clock);
         external_count_pin <= 1'b0;
      end
   endtask
   // Code 3 fires every source at once, since none of them may pass then.
   task automatic evt(input logic [1:0] s);
      @(posedge clock);
      tick_timer_wrap <= s[0];
      period_timer_match <= s[1];
      gate_input_pin <= ~^s;
      @(posedge clock);
      tick_timer_wrap <= 1'b0;
      period_timer_match <= 1'b0;
      gate_input_pin <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ---- gtm_timer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "gtm_map.vh"
module gtm_timer #(
   parameter PS_W = 3
) (
   input wire clock,
   input wire rst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire gate_input_pin,
   input wire external_count_pin,
   input wire crystal_tick,
   input wire low_freq_internal_osc,
   input wire tick_timer_wrap,
   input wire period_timer_match,
   input wire capture_event,
   input wire special_event,
   input wire sleep_mode,
   output reg compare_match_r,
   output reg irq_r,
   output reg wake_r
);
   reg [7:0] ctrl_r;
   reg [7:0] gate_r;
   reg [7:0] ien_r;
   reg [7:0] irqc_r;
   reg gflag_r;
   reg oflag_r;
   reg [15:0] count_r;
   reg [15:0] cc_r;
   reg [PS_W-1:0] ps_r;
   reg [1:0] instr_r;
   reg ext_s1_r;
   reg ext_s2_r;
   reg ext_d_r;
   reg tog_r;
   reg gsrc_d_r;
   reg gval_d_r;
   reg spm_seen_r;
   reg [7:0] aw_addr_r;
   reg aw_have_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg w_have_r;

   function sel_bit;
      input [1:0] code;
      input [3:0] srcs;
      begin
         sel_bit = srcs[code];
      end
   endfunction

   // Gate source with reserved code reading low before the polarity is applied.
   wire [1:0] gss = gate_r[`GTM_GSS_HI:`GTM_GSS_LO];
   wire gsrc_raw = sel_bit(gss, {1'b0, period_timer_match, tick_timer_wrap,
      gate_input_pin});
   // Polarity 0 inverts so that a high value always means count enabled.
   wire gsrc = gsrc_raw ~^ gate_r[`GTM_GPOL];
   wire gsrc_rise = gsrc & ~gsrc_d_r;
   wire tog_lvl = gate_r[`GTM_GTM] ? tog_r : gsrc;
   wire spm = gate_r[`GTM_GSPM];
   wire arm = gate_r[`GTM_GARM];
   // In single-pulse mode only the first window after arming passes.
   wire gval = spm ? (tog_lvl & (arm | spm_seen_r) & spm_seen_r) : tog_lvl;
   wire gval_fall = gval_d_r & ~gval;

   // Clock source selection and input edge.
   wire [1:0] cs = ctrl_r[`GTM_CS_HI:`GTM_CS_LO];
   wire ext_raw = ctrl_r[`GTM_OSCEN] ? crystal_tick : external_count_pin;
   // The bypass path still needs an edge detector; without a second clock it is one stage shorter.
   wire ext_lvl = ctrl_r[`GTM_SYNCB] ? ext_s1_r : ext_s2_r;
   wire ext_rise = ext_lvl & ~ext_d_r;
   wire src_tick = sel_bit(cs, {ext_rise & 1'b0 | low_freq_internal_osc,
      ext_rise, 1'b1, instr_r == `GTM_INSTR_DIV});
   wire in_sleep_ok = ~sleep_mode | (cs[1] & ctrl_r[`GTM_SYNCB]);
   wire run = ctrl_r[`GTM_ON] & (~gate_r[`GTM_GE] | gval) & in_sleep_ok;
   wire [2:0] ps_lim = (3'h1 << ctrl_r[`GTM_PS_HI:`GTM_PS_LO]) - 3'h1;
   wire ps_done = ps_r == ps_lim;

   // Bus write decode.
   reg sel_ctrl;
   reg sel_gate;
   reg sel_cntl;
   reg sel_cnth;
   reg sel_flag;
   reg sel_ien;
   reg sel_irqc;
   reg sel_ccl;
   reg sel_cch;
   reg sel_ok;

   // One select per register keeps the address compare in a single place.
   always @* begin
      sel_ctrl = 1'b0;
      sel_gate = 1'b0;
      sel_cntl = 1'b0;
      sel_cnth = 1'b0;
      sel_flag = 1'b0;
      sel_ien = 1'b0;
      sel_irqc = 1'b0;
      sel_ccl = 1'b0;
      sel_cch = 1'b0;
      sel_ok = 1'b1;
      case (aw_addr_r)
         `GTM_ADDR_CTRL: sel_ctrl = 1'b1;
         `GTM_ADDR_GATE: sel_gate = 1'b1;
         `GTM_ADDR_CNTL: sel_cntl = 1'b1;
         `GTM_ADDR_CNTH: sel_cnth = 1'b1;
         `GTM_ADDR_FLAG: sel_flag = 1'b1;
         `GTM_ADDR_IEN: sel_ien = 1'b1;
         `GTM_ADDR_IRQC: sel_irqc = 1'b1;
         `GTM_ADDR_CCL: sel_ccl = 1'b1;
         `GTM_ADDR_CCH: sel_cch = 1'b1;
         default: sel_ok = 1'b0;
      endcase
   end

   wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
   wire wr_ctrl = wr_go & sel_ctrl;
   wire wr_gate = wr_go & sel_gate;
   wire wr_cnt = wr_go & (sel_cntl | sel_cnth);
   wire wr_flag = wr_go & sel_flag;
   wire wr_ien = wr_go & sel_ien;
   wire wr_irqc = wr_go & sel_irqc;
   wire wr_ccl = wr_go & sel_ccl;
   wire wr_cch = wr_go & sel_cch;
   wire wr_ok = sel_ok;
   wire [7:0] wb = w_data_r[7:0];
   wire wl = w_strb_r[0];

   reg [15:0] count_nxt;
   reg [PS_W-1:0] ps_nxt;
   reg wrap_nxt;

   // A write beats a special event, which beats counting.
   // The wrap flag follows only a real increment, so a clear at the top never sets it.
   always @* begin
      count_nxt = count_r;
      ps_nxt = ps_r;
      wrap_nxt = 1'b0;
      if (wr_cnt) begin
         ps_nxt = {PS_W{1'b0}};
         if (wl & sel_cntl)
            count_nxt[7:0] = wb;
         if (wl & sel_cnth)
            count_nxt[15:8] = wb;
      end else if (special_event) begin
         count_nxt = 16'h0000;
         ps_nxt = {PS_W{1'b0}};
      end else if (run & src_tick) begin
         if (ps_done) begin
            ps_nxt = {PS_W{1'b0}};
            count_nxt = count_r + 16'h0001;
            wrap_nxt = count_r == 16'hFFFF;
         end else
            ps_nxt = ps_r + {{(PS_W-1){1'b0}}, 1'b1};
      end
   end

   reg [7:0] rd_byte;
   reg rd_err;

   always @* begin
      rd_byte = 8'h00;
      rd_err = 1'b0;
      case (s_axi_araddr)
         `GTM_ADDR_CTRL: rd_byte = ctrl_r;
         `GTM_ADDR_GATE: rd_byte = {gate_r[7:3], gval, gate_r[1:0]};
         `GTM_ADDR_CNTL: rd_byte = count_r[7:0];
         `GTM_ADDR_CNTH: rd_byte = count_r[15:8];
         `GTM_ADDR_FLAG: rd_byte = {gflag_r, 6'h00, oflag_r};
         `GTM_ADDR_IEN: rd_byte = ien_r;
         `GTM_ADDR_IRQC: rd_byte = irqc_r;
         `GTM_ADDR_CCL: rd_byte = cc_r[7:0];
         `GTM_ADDR_CCH: rd_byte = cc_r[15:8];
         default: rd_err = 1'b1;
      endcase
   end

   // Overflow only requests while counting is switched on.
   wire ovf_req = oflag_r & ien_r[`GTM_FLAG_OVF] & ctrl_r[`GTM_ON];
   wire gate_req = gflag_r & ien_r[`GTM_FLAG_GATE];

   always @(posedge clock) begin
      if (rst) begin
         instr_r <= 2'h0;
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_d_r <= 1'b0;
         gsrc_d_r <= 1'b0;
         gval_d_r <= 1'b0;
      end else begin
         instr_r <= instr_r + 2'h1;
         ext_s1_r <= ext_raw;
         ext_s2_r <= ext_s1_r;
         ext_d_r <= ext_lvl;
         gsrc_d_r <= gsrc;
         gval_d_r <= gval;
      end
   end

   // Toggle flip-flop and single-pulse window.
   always @(posedge clock) begin
      if (rst) begin
         tog_r <= 1'b0;
         spm_seen_r <= 1'b0;
      end else begin
         if (~gate_r[`GTM_GTM] | ~ctrl_r[`GTM_ON])
            tog_r <= 1'b0;
         else if (gsrc_rise)
            tog_r <= ~tog_r;
         if (~spm | ~arm)
            spm_seen_r <= 1'b0;
         // Only a fresh incrementing edge opens the window, never a level already high.
         else if (~spm_seen_r & gsrc_rise & (~gate_r[`GTM_GTM] | ~tog_r))
            spm_seen_r <= 1'b1;
      end
   end

   // Control, gate and flag registers.
   always @(posedge clock) begin
      if (rst) begin
         ctrl_r <= 8'h00;
         gate_r <= 8'h00;
         ien_r <= 8'h00;
         irqc_r <= 8'h00;
         cc_r <= 16'h0000;
         gflag_r <= 1'b0;
         oflag_r <= 1'b0;
      end else begin
         if (wr_ctrl & wl)
            ctrl_r <= wb & `GTM_CTRL_WMASK;
         if (wr_gate & wl)
            gate_r <= wb & `GTM_GATE_WMASK;
         else if (spm & arm & spm_seen_r & ~tog_lvl)
            gate_r[`GTM_GARM] <= 1'b0;
         if (wr_ien & wl)
            ien_r <= wb;
         if (wr_irqc & wl)
            irqc_r <= wb;
         if (capture_event)
            cc_r <= count_r;
         else if (wr_ccl & wl)
            cc_r[7:0] <= wb;
         else if (wr_cch & wl)
            cc_r[15:8] <= wb;
         // A new event wins over a clear in the same cycle.
         if (gval_fall)
            gflag_r <= 1'b1;
         else if (wr_flag & wl & wb[`GTM_FLAG_GATE])
            gflag_r <= 1'b0;
         if (wrap_nxt)
            oflag_r <= 1'b1;
         else if (wr_flag & wl & wb[`GTM_FLAG_OVF])
            oflag_r <= 1'b0;
      end
   end

   // Count and prescaler.
   always @(posedge clock) begin
      if (rst) begin
         count_r <= 16'h0000;
         ps_r <= {PS_W{1'b0}};
      end else begin
         count_r <= count_nxt;
         ps_r <= ps_nxt;
      end
   end

   // Outputs toward the processor and compare unit.
   always @(posedge clock) begin
      if (rst) begin
         compare_match_r <= 1'b0;
         irq_r <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         compare_match_r <= cc_r == count_r;
         irq_r <= irqc_r[`GTM_IRQ_GIE] & irqc_r[`GTM_IRQ_PERIPHERAL_IRQ_ENABLE] & (ovf_req | gate_req);
         wake_r <= sleep_mode & oflag_r & ien_r[`GTM_FLAG_OVF] &
            irqc_r[`GTM_IRQ_PERIPHERAL_IRQ_ENABLE] & ctrl_r[`GTM_ON];
      end
   end

   // AXI4-Lite write channels; address and data taken in either order.
   always @(posedge clock) begin
      if (rst) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `GTM_RESP_OK;
      end else begin
         s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
         s_axi_wready <= ~w_have_r & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `GTM_RESP_OK : `GTM_RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // AXI4-Lite read channel.
   always @(posedge clock) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `GTM_RESP_OK;
      end else begin
         s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_err ? `GTM_RESP_SLVERR : `GTM_RESP_OK;
            s_axi_rdata <= {24'h000000, rd_byte};
         end else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- gtm_timer_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module gtm_timer_monitor (
   input wire logic clock,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_mode,
   input wire logic irq_r,
   input wire logic wake_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_rst;
      disable iff (1'b0) rst |=> !irq_r && !wake_r && !s_axi_bvalid && !s_axi_rvalid;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs busy in reset");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_blat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_blat: assert property (p_blat) else $error("write answer late");
   property p_rword; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rresp[0];
   endproperty
   a_rword: assert property (p_rword) else $error("read word malformed");
   property p_arpulse; s_axi_arready |=> !s_axi_arready; endproperty
   a_arpulse: assert property (p_arpulse) else $error("read ready held");
   property p_wake; $rose(wake_r) |-> $past(sleep_mode); endproperty
   a_wake: assert property (p_wake) else $error("wake outside sleep");
endmodule
bind gtm_timer gtm_timer_monitor u_mon (.clock, .rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_mode,
   .irq_r, .wake_r);
`default_nettype wire

// ---- test_gated_16bit_timer_gate_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_gated_16bit_timer_gate_ctrl;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic cap = 0, spec = 0, slp = 0;
   wire logic awready, wready, bvalid, arready, rvalid, cmp, irq, wake, gpin, tick, per, epin;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   int bad_count = 0;
   int check_count = 0;
   // Columns: address, write data, expected read, expected response.
   logic [25:0] rows [7] = '{{8'h00, 8'h02, 8'h00, 2'h0}, {8'h1C, 8'hA5, 8'hA5, 2'h0},
      {8'h20, 8'h5A, 8'h5A, 2'h0}, {8'h14, 8'h81, 8'h81, 2'h0}, {8'h18, 8'hC0, 8'hC0, 2'h0},
      {8'h08, 8'h34, 8'h34, 2'h0}, {8'h24, 8'h77, 8'h00, 2'h2}};
   always #10 clock = ~clock;
   gtm_timer DUT (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .gate_input_pin(gpin), .external_count_pin(epin), .crystal_tick(1'b0),
      .low_freq_internal_osc(1'b0), .tick_timer_wrap(tick), .period_timer_match(per),
      .capture_event(cap), .special_event(spec), .sleep_mode(slp), .compare_match_r(cmp),
      .irq_r(irq), .wake_r(wake));
   gtm_partner p (.clock(clock), .gate_input_pin(gpin), .tick_timer_wrap(tick),
      .period_timer_match(per), .external_count_pin(epin));
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk({rresp, rdata}, {er, 24'h0, e});
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      $display("FAIL %0t watchdog", $time);
      report_and_stop;
   end
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i][25:18], rows[i][17:10]);
         rc(rows[i][25:18], rows[i][9:2], rows[i][1:0]);
      end
      done("rows");
      rst <= 1'b1;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rc(8'h00, 8'h00, 2'h0);
      rc(8'h04, 8'h00, 2'h0);
      rc(8'h14, 8'h00, 2'h0);
      done("reset");
      for (int c = 0; c < 4; c++) begin
         wr(8'h00, {2'h2, c[1:0], 4'h1});
         wr(8'h08, 8'h00);
         wr(8'h0C, 8'h00);
         p.pins(16, 3);
         rc(8'h08, 8'h10 >> c, 2'h0);
      end
      done("prescale");
      wr(8'h00, 8'h81);
      wr(8'h04, 8'hC0);
      wr(8'h08, 8'h00);
      p.pins(4, 4);
      rc(8'h04, 8'hC4, 2'h0);
      rc(8'h08, 8'h04, 2'h0);
      p.gate_input_pin <= 1'b0;
      p.pins(4, 4);
      rc(8'h08, 8'h04, 2'h0);
      rc(8'h10, 8'h80, 2'h0);
      wr(8'h10, 8'h81);
      done("gate");
      // Gate enable stays clear here, so the flag must work without it.
      for (int s = 0; s < 4; s++) begin
         wr(8'h04, {6'h10, s[1:0]});
         p.evt(s[1:0]);
         rc(8'h10, (s == 3) ? 8'h00 : 8'h80, 2'h0);
         wr(8'h10, 8'h81);
      end
      done("sources");
      wr(8'h04, 8'hD0);
      wr(8'h08, 8'h00);
      wr(8'h0C, 8'h00);
      wr(8'h00, 8'h41);
      wr(8'h04, 8'hD8);
      repeat (2) begin
         p.gate_input_pin <= 1'b1;
         repeat (10) @(posedge clock);
         p.gate_input_pin <= 1'b0;
         repeat (3) @(posedge clock);
      end
      rc(8'h08, 8'h09, 2'h0);
      rc(8'h04, 8'hD0, 2'h0);
      rc(8'h10, 8'h80, 2'h0);
      wr(8'h04, 8'h00);
      wr(8'h10, 8'h81);
      done("single");
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h00);
      wr(8'h08, 8'hF0);
      wr(8'h0C, 8'hFF);
      wr(8'h14, 8'h01);
      wr(8'h18, 8'hC0);
      wr(8'h00, 8'h41);
      while (!irq) @(posedge clock);
      wr(8'h00, 8'h00);
      rc(8'h10, 8'h01, 2'h0);
      wr(8'h10, 8'h81);
      repeat (2) @(posedge clock);
      chk({33'h0, irq}, 34'h0);
      spec <= 1'b1;
      @(posedge clock);
      spec <= 1'b0;
      rc(8'h08, 8'h00, 2'h0);
      rc(8'h10, 8'h00, 2'h0);
      cap <= 1'b1;
      @(posedge clock);
      cap <= 1'b0;
      repeat (3) @(posedge clock);
      chk({33'h0, cmp}, 34'h1);
      done("overflow");
      slp <= 1'b1;
      wr(8'h08, 8'hFF);
      wr(8'h0C, 8'hFF);
      wr(8'h00, 8'h85);
      p.pins(1, 4);
      repeat (4) @(posedge clock);
      chk({33'h0, wake}, 34'h1);
      done("sleep");
      report_and_stop;
   end
endmodule
`default_nettype wire
